// file: sys_ctl_defs.vh
// Purpose: shared constants for the system-control protection and reset block
// Assumes: AXI4-Lite register access, 32-bit data, byte addresses below 0x1000
// Notes: included by every design file of the block
// Notes on behaviour
// - the power-on-reset circuit is switched off while the disable code field holds 0x5AA5.
// - any other written code, or a chip reset from pin, watchdog, low voltage or software, turns it on again.
// - the disable code field is protected and only takes writes while protection is unlocked.
// - bit 31 of the de-bounce register enables reset-pin filtering; 0, the default, bypasses it.
// - the reset pin is filtered over a 16-bit cycle count that defaults to 0x04B0.
// - protected registers are locked from power-on reset until the unlock sequence completes.
// - a wrong value, wrong order or a write to another address aborts the unlock attempt.
// - bit 0 of the protection register reads 1 when protection is off and 0 when it is on.
// - once unlocked, any write to the protection register locks again and clears bit 0.
// - while locked, writes to protected registers are silently dropped.
`ifndef SYS_CTL_DEFS_VH
`define SYS_CTL_DEFS_VH

`define ADDR_W 12
`define DATA_W 32

`define OFS_POR_DISABLE_CTL 12'h100
`define OFS_RESET_PIN_DEBOUNCE_CTL 12'h10C
`define OFS_WRITE_PROTECT_CTL 12'h1FC

`define POR_CODE_MSB 15
`define POR_CODE_RST 16'h0000
`define POR_OFF_CODE 16'h5AA5

`define FILTER_ON_BIT 31
`define FILTER_CNT_MSB 15
`define FILTER_CNT_RST 16'h04B0

`define PROTECT_STATUS_BIT 0
`define UNLOCK_KEY0 8'h59
`define UNLOCK_KEY1 8'h16
`define UNLOCK_KEY2 8'h88

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// file: protect_unlock_seq.v
// Purpose: three-key unlock sequencer for register write protection
// Assumes: i_wr is a one-cycle pulse per completed bus write
// Notes: i_key_ok is low when the low byte lane was not written
`timescale 1ns/10ps
`include "sys_ctl_defs.vh"
module protect_unlock_seq (
  input wire i_clk,
  input wire i_rst,
  input wire i_wr,
  input wire i_wr_ctl,
  input wire i_key_ok,
  input wire [7:0] i_key,
  output reg o_unlocked_q
);
  localparam ST_IDLE = 2'b00;
  localparam ST_GOT0 = 2'b01;
  localparam ST_GOT1 = 2'b10;
  localparam ST_OPEN = 2'b11;

  reg [1:0] state_q;
  reg [1:0] state_d;

  always @* begin
    state_d = state_q;
    if (i_wr) begin
      case (state_q)
        ST_OPEN: begin
          if (i_wr_ctl) begin
            state_d = ST_IDLE;
          end
        end
        ST_GOT0: begin
          if (i_wr_ctl && i_key_ok && i_key == `UNLOCK_KEY1) begin
            state_d = ST_GOT1;
          end else if (i_wr_ctl && i_key_ok && i_key == `UNLOCK_KEY0) begin
            state_d = ST_GOT0;
          end else begin
            state_d = ST_IDLE;
          end
        end
        ST_GOT1: begin
          if (i_wr_ctl && i_key_ok && i_key == `UNLOCK_KEY2) begin
            state_d = ST_OPEN;
          end else if (i_wr_ctl && i_key_ok && i_key == `UNLOCK_KEY0) begin
            state_d = ST_GOT0;
          end else begin
            state_d = ST_IDLE;
          end
        end
        default: begin
          if (i_wr_ctl && i_key_ok && i_key == `UNLOCK_KEY0) begin
            state_d = ST_GOT0;
          end else begin
            state_d = ST_IDLE;
          end
        end
      endcase
    end
  end

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
      o_unlocked_q <= 1'b0;
    end else begin
      state_q <= state_d;
      o_unlocked_q <= (state_d == ST_OPEN);
    end
  end
endmodule

// file: reset_pin_filter.v
// Purpose: de-bounce filter for the active-low external reset pin
// Assumes: the pin is asynchronous; the filter count is in i_clk cycles
// Notes: with filtering on, a change must hold for count+1 synchronised cycles before it is passed on; with it off, it passes at once
`timescale 1ns/10ps
`include "sys_ctl_defs.vh"
module reset_pin_filter (
  input wire i_clk,
  input wire i_rst,
  input wire i_pin_n,
  input wire i_filter_on,
  input wire [`FILTER_CNT_MSB:0] i_filter_count,
  output reg o_reset_req_q
);
  reg sync1_q;
  reg sync2_q;
  reg level_q;
  reg [`FILTER_CNT_MSB:0] cnt_q;

  // pin rests high, so the synchroniser resets to the released level
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      sync1_q <= i_pin_n;
      sync2_q <= sync1_q;
    end
  end

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      level_q <= 1'b1;
      cnt_q <= {(`FILTER_CNT_MSB + 1){1'b0}};
      o_reset_req_q <= 1'b0;
    end else begin
      if (!i_filter_on) begin
        level_q <= sync2_q;
        cnt_q <= {(`FILTER_CNT_MSB + 1){1'b0}};
        o_reset_req_q <= ~sync2_q;
      end else if (sync2_q == level_q) begin
        cnt_q <= {(`FILTER_CNT_MSB + 1){1'b0}};
        o_reset_req_q <= ~level_q;
      end else if (cnt_q >= i_filter_count) begin
        level_q <= sync2_q;
        cnt_q <= {(`FILTER_CNT_MSB + 1){1'b0}};
        o_reset_req_q <= ~sync2_q;
      end else begin
        cnt_q <= cnt_q + {{`FILTER_CNT_MSB{1'b0}}, 1'b1};
        o_reset_req_q <= ~level_q;
      end
    end
  end
endmodule

// file: sys_protect_reset_ctl.v
// Purpose: write-protection lock, power-on-reset disable and reset-pin filter registers
// Assumes: AXI4-Lite slave on i_clk; chip-reset inputs are single-clock pulses from local logic
// Notes: unmapped addresses answer SLVERR; locked writes answer OKAY and change nothing
`timescale 1ns/10ps
`include "sys_ctl_defs.vh"
module sys_protect_reset_ctl (
  input wire i_clk,
  input wire i_rst,
  input wire [`ADDR_W-1:0] i_s_axi_awaddr,
  input wire i_s_axi_awvalid,
  output reg o_s_axi_awready,
  input wire [`DATA_W-1:0] i_s_axi_wdata,
  input wire [3:0] i_s_axi_wstrb,
  input wire i_s_axi_wvalid,
  output reg o_s_axi_wready,
  output reg [1:0] o_s_axi_bresp,
  output reg o_s_axi_bvalid,
  input wire i_s_axi_bready,
  input wire [`ADDR_W-1:0] i_s_axi_araddr,
  input wire i_s_axi_arvalid,
  output reg o_s_axi_arready,
  output reg [`DATA_W-1:0] o_s_axi_rdata,
  output reg [1:0] o_s_axi_rresp,
  output reg o_s_axi_rvalid,
  input wire i_s_axi_rready,
  input wire i_reset_pin_n,
  input wire i_watchdog_reset,
  input wire i_low_voltage_reset,
  input wire i_sw_chip_reset,
  output reg o_por_off,
  output wire o_reset_pin_req,
  output wire o_protect_off
);
  reg [`ADDR_W-1:0] awaddr_q;
  reg [`DATA_W-1:0] wdata_q;
  reg [3:0] wstrb_q;

  reg [`POR_CODE_MSB:0] por_code_q;
  reg filter_on_q;
  reg [`FILTER_CNT_MSB:0] filter_count_q;

  wire wr_fire;
  wire wr_por;
  wire wr_deb;
  wire wr_ctl;
  wire wr_mapped;
  wire chip_reset;
  wire unlocked;
  wire pin_req;

  reg [`DATA_W-1:0] rd_data;
  reg rd_hit;

  // address and data are held until both have arrived, in either order
  assign wr_fire = !o_s_axi_awready && !o_s_axi_wready && !o_s_axi_bvalid;
  assign wr_por = (awaddr_q == `OFS_POR_DISABLE_CTL);
  assign wr_deb = (awaddr_q == `OFS_RESET_PIN_DEBOUNCE_CTL);
  assign wr_ctl = (awaddr_q == `OFS_WRITE_PROTECT_CTL);
  assign wr_mapped = wr_por || wr_deb || wr_ctl;

  // a filtered pin reset counts as a chip reset just like the other sources
  assign chip_reset = pin_req || i_watchdog_reset || i_low_voltage_reset || i_sw_chip_reset;

  assign o_protect_off = unlocked;
  assign o_reset_pin_req = pin_req;

  protect_unlock_seq u_unlock (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_wr(wr_fire),
    .i_wr_ctl(wr_ctl),
    .i_key_ok(wstrb_q[0]),
    .i_key(wdata_q[7:0]),
    .o_unlocked_q(unlocked)
  );

  reset_pin_filter u_pin_filter (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_pin_n(i_reset_pin_n),
    .i_filter_on(filter_on_q),
    .i_filter_count(filter_count_q),
    .o_reset_req_q(pin_req)
  );

  // write address channel
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_s_axi_awready <= 1'b1;
      awaddr_q <= {`ADDR_W{1'b0}};
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        o_s_axi_awready <= 1'b0;
        awaddr_q <= {i_s_axi_awaddr[`ADDR_W-1:2], 2'b00};
      end else if (o_s_axi_bvalid && i_s_axi_bready) begin
        o_s_axi_awready <= 1'b1;
      end
    end
  end

  // write data channel
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_s_axi_wready <= 1'b1;
      wdata_q <= {`DATA_W{1'b0}};
      wstrb_q <= 4'h0;
    end else begin
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        o_s_axi_wready <= 1'b0;
        wdata_q <= i_s_axi_wdata;
        wstrb_q <= i_s_axi_wstrb;
      end else if (o_s_axi_bvalid && i_s_axi_bready) begin
        o_s_axi_wready <= 1'b1;
      end
    end
  end

  // write response: one cycle after both halves are held
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (wr_fire) begin
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (o_s_axi_bvalid && i_s_axi_bready) begin
        o_s_axi_bvalid <= 1'b0;
      end
    end
  end

  // power-on-reset disable code, protected
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      por_code_q <= `POR_CODE_RST;
    end else begin
      if (chip_reset) begin
        // chip reset outranks a write landing in the same cycle
        por_code_q <= `POR_CODE_RST;
      end else if (wr_fire && wr_por && unlocked) begin
        if (wstrb_q[0]) begin
          por_code_q[7:0] <= wdata_q[7:0];
        end
        if (wstrb_q[1]) begin
          por_code_q[15:8] <= wdata_q[15:8];
        end
      end
    end
  end

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_por_off <= 1'b0;
    end else begin
      o_por_off <= (por_code_q == `POR_OFF_CODE);
    end
  end

  // reset-pin de-bounce control, not protected
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      filter_on_q <= 1'b0;
      filter_count_q <= `FILTER_CNT_RST;
    end else begin
      if (wr_fire && wr_deb) begin
        if (wstrb_q[3]) begin
          filter_on_q <= wdata_q[`FILTER_ON_BIT];
        end
        if (wstrb_q[0]) begin
          filter_count_q[7:0] <= wdata_q[7:0];
        end
        if (wstrb_q[1]) begin
          filter_count_q[15:8] <= wdata_q[15:8];
        end
      end
    end
  end

  // read decode; reserved bits read as zero
  always @* begin
    rd_data = {`DATA_W{1'b0}};
    rd_hit = 1'b1;
    case ({i_s_axi_araddr[`ADDR_W-1:2], 2'b00})
      `OFS_POR_DISABLE_CTL: begin
        rd_data[`POR_CODE_MSB:0] = por_code_q;
      end
      `OFS_RESET_PIN_DEBOUNCE_CTL: begin
        rd_data[`FILTER_ON_BIT] = filter_on_q;
        rd_data[`FILTER_CNT_MSB:0] = filter_count_q;
      end
      `OFS_WRITE_PROTECT_CTL: begin
        rd_data[`PROTECT_STATUS_BIT] = unlocked;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // read channel: data one cycle after the address is taken
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_s_axi_arready <= 1'b1;
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= {`DATA_W{1'b0}};
      o_s_axi_rresp <= `RESP_OKAY;
    end else begin
      if (i_s_axi_arvalid && o_s_axi_arready) begin
        o_s_axi_arready <= 1'b0;
        o_s_axi_rvalid <= 1'b1;
        o_s_axi_rdata <= rd_data;
        o_s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (o_s_axi_rvalid && i_s_axi_rready) begin
        o_s_axi_rvalid <= 1'b0;
        o_s_axi_arready <= 1'b1;
      end
    end
  end
endmodule

// file: sys_protect_reset_ctl_chk.sv
// Purpose: port-level checks of the protection and reset control block
// Assumes: single clock domain; asynchronous active-high reset
// Notes: bound to every instance of the top module
`timescale 1ns/10ps
`include "sys_ctl_defs.vh"
module sys_protect_reset_ctl_chk (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [11:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  input wire logic o_s_axi_awready,
  input wire logic i_s_axi_wvalid,
  input wire logic o_s_axi_wready,
  input wire logic o_s_axi_bvalid,
  input wire logic [11:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  input wire logic o_s_axi_arready,
  input wire logic [1:0] o_s_axi_rresp,
  input wire logic o_s_axi_rvalid,
  input wire logic i_watchdog_reset,
  input wire logic o_por_off,
  input wire logic o_protect_off
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  wire wr_take = i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
  wire wp_hit = (i_s_axi_awaddr >> 2) == (`OFS_WRITE_PROTECT_CTL >> 2);
  wire rd_map = (i_s_axi_araddr >> 2) == (`OFS_WRITE_PROTECT_CTL >> 2) ||
    (i_s_axi_araddr >> 2) == (`OFS_POR_DISABLE_CTL >> 2) ||
    (i_s_axi_araddr >> 2) == (`OFS_RESET_PIN_DEBOUNCE_CTL >> 2);
  a_wr_answer: assert property (wr_take |-> ##[1:2] o_s_axi_bvalid)
    else $error("write response late");
  a_rd_answer: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
    else $error("read data late");
  a_b_blocks: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
    else $error("write accepted during response");
  a_r_blocks: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
    else $error("read accepted during response");
  a_unmapped_rd: assert property (i_s_axi_arvalid && o_s_axi_arready && !rd_map
    |=> o_s_axi_rresp == `RESP_SLVERR) else $error("unmapped read not refused");
  a_lock_start: assert property ($past(i_rst) |-> !o_protect_off && !o_por_off)
    else $error("unlocked or por off after reset");
  a_unlock_cause: assert property ($rose(o_protect_off) |->
    o_s_axi_bvalid && !$past(o_s_axi_bvalid)) else $error("unlock without write");
  a_relock_write: assert property (wr_take && wp_hit && o_protect_off
    |-> ##[1:4] !o_protect_off) else $error("protection not restored");
  a_por_restore: assert property (i_watchdog_reset |-> ##[1:3] !o_por_off)
    else $error("por circuit stays off after chip reset");
endmodule
bind sys_protect_reset_ctl sys_protect_reset_ctl_chk chk (.*);

// file: sys_protect_reset_ctl_tb_top.sv
// Purpose: self-checking bench for the protection and reset control block
// Assumes: AXI4-Lite master driven by non-blocking assignment after rising edges
// Notes: filter count is set small so the pin tests stay short
`timescale 1ns/10ps
`include "sys_ctl_defs.vh"
module sys_protect_reset_ctl_tb_top;
  logic i_clk = 0, i_rst = 1;
  logic [11:0] i_s_axi_awaddr = 0, i_s_axi_araddr = 0;
  logic [31:0] i_s_axi_wdata = 0, o_s_axi_rdata, rd;
  logic [3:0] i_s_axi_wstrb = 4'hF;
  logic i_s_axi_awvalid = 0, i_s_axi_wvalid = 0, i_s_axi_bready = 0;
  logic i_s_axi_arvalid = 0, i_s_axi_rready = 0, i_reset_pin_n = 1;
  logic i_watchdog_reset = 0, i_low_voltage_reset = 0, i_sw_chip_reset = 0;
  logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
  logic [1:0] o_s_axi_bresp, o_s_axi_rresp, rs;
  logic o_por_off, o_reset_pin_req, o_protect_off;
  int error_cnt = 0, num_checks = 0;
  sys_protect_reset_ctl uut (.*);
  always #25 i_clk = ~i_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge i_clk);
    n = 0;
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= d;
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wvalid <= 1'b1;
    i_s_axi_bready <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
      if (o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
      if (o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
    end while (!o_s_axi_bvalid && n < 50);
    r = o_s_axi_bresp;
    i_s_axi_bready <= 1'b0;
    if (n >= 50) error_cnt++;
  endtask
  task automatic rdx(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge i_clk);
    n = 0;
    i_s_axi_araddr <= a;
    i_s_axi_arvalid <= 1'b1;
    i_s_axi_rready <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
      if (o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
    end while (!o_s_axi_rvalid && n < 50);
    d = o_s_axi_rdata;
    r = o_s_axi_rresp;
    i_s_axi_rready <= 1'b0;
    if (n >= 50) error_cnt++;
  endtask
  // writes that must be taken without error
  task automatic wx(input logic [11:0] a, input logic [31:0] d);
    wr(a, d, rs);
    chk({30'h0, rs}, {30'h0, `RESP_OKAY});
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    rdx(a, rd, rs);
    chk(rd, e);
  endtask
  task automatic keys(input logic [7:0] k0, input logic [7:0] k1, input logic [7:0] k2);
    wx(`OFS_WRITE_PROTECT_CTL, {24'h0, k0});
    wx(`OFS_WRITE_PROTECT_CTL, {24'h0, k1});
    wx(`OFS_WRITE_PROTECT_CTL, {24'h0, k2});
  endtask
  task automatic t_reset;
    rchk(`OFS_WRITE_PROTECT_CTL, 32'h0);
    rchk(`OFS_RESET_PIN_DEBOUNCE_CTL, 32'h000004B0);
    rchk(`OFS_POR_DISABLE_CTL, 32'h0);
    wx(`OFS_POR_DISABLE_CTL, 32'h00005AA5);
    rchk(`OFS_POR_DISABLE_CTL, 32'h0);
    chk(o_por_off, 1'b0);
  endtask
  task automatic t_abort;
    wx(`OFS_WRITE_PROTECT_CTL, 32'h59);
    wx(`OFS_WRITE_PROTECT_CTL, 32'h16);
    wx(`OFS_RESET_PIN_DEBOUNCE_CTL, 32'h000004B0);
    wx(`OFS_WRITE_PROTECT_CTL, 32'h88);
    rchk(`OFS_WRITE_PROTECT_CTL, 32'h0);
    keys(8'h59, 8'h17, 8'h88);
    rchk(`OFS_WRITE_PROTECT_CTL, 32'h0);
    keys(8'h16, 8'h59, 8'h88);
    rchk(`OFS_WRITE_PROTECT_CTL, 32'h0);
    wx(`OFS_WRITE_PROTECT_CTL, 32'h59);
    wx(`OFS_WRITE_PROTECT_CTL, 32'h17);
    keys(8'h59, 8'h16, 8'h88);
    rchk(`OFS_WRITE_PROTECT_CTL, 32'h1);
    chk(o_protect_off, 1'b1);
  endtask
  // each pass re-arms the code, then a written 0x1234 (first pass) or one reset source knocks it out
  task automatic t_por;
    for (int k = 0; k < 5; k++) begin
      wx(`OFS_POR_DISABLE_CTL, 32'h00005AA5);
      rchk(`OFS_POR_DISABLE_CTL, 32'h00005AA5);
      chk(o_por_off, 1'b1);
      if (k == 0) wx(`OFS_POR_DISABLE_CTL, 32'h00001234);
      @(posedge i_clk);
      i_watchdog_reset <= (k == 1);
      i_low_voltage_reset <= (k == 2);
      i_sw_chip_reset <= (k == 3);
      i_reset_pin_n <= (k != 4);
      repeat (6) @(posedge i_clk);
      chk(o_reset_pin_req, k == 4);
      {i_watchdog_reset, i_low_voltage_reset, i_sw_chip_reset} <= 3'b0;
      i_reset_pin_n <= 1'b1;
      repeat (8) @(posedge i_clk);
      chk(o_por_off, 1'b0);
      rchk(`OFS_POR_DISABLE_CTL, (k == 0) ? 32'h00001234 : 32'h0);
    end
  endtask
  task automatic t_relock;
    wx(`OFS_WRITE_PROTECT_CTL, 32'h59);
    rchk(`OFS_WRITE_PROTECT_CTL, 32'h0);
    chk(o_protect_off, 1'b0);
    wx(`OFS_POR_DISABLE_CTL, 32'h00005AA5);
    rchk(`OFS_POR_DISABLE_CTL, 32'h0);
  endtask
  // a second reset in mid-run must lock again and clear the disable code
  task automatic t_rerst;
    keys(8'h59, 8'h16, 8'h88);
    chk(o_protect_off, 1'b1);
    wx(`OFS_POR_DISABLE_CTL, 32'h00005AA5);
    rchk(`OFS_POR_DISABLE_CTL, 32'h00005AA5);
    chk(o_por_off, 1'b1);
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    chk(o_protect_off, 1'b0);
    chk(o_por_off, 1'b0);
    rchk(`OFS_WRITE_PROTECT_CTL, 32'h0);
    rchk(`OFS_POR_DISABLE_CTL, 32'h0);
  endtask
  // a short count keeps the run brief; the hold needed is count+1 cycles, and the 2 sync stages only add delay
  task automatic t_filter;
    wx(`OFS_RESET_PIN_DEBOUNCE_CTL, 32'h80000005);
    rchk(`OFS_RESET_PIN_DEBOUNCE_CTL, 32'h80000005);
    i_reset_pin_n <= 1'b0;
    repeat (4) @(posedge i_clk);
    i_reset_pin_n <= 1'b1;
    repeat (12) begin
      @(posedge i_clk);
      chk(o_reset_pin_req, 1'b0);
    end
    i_reset_pin_n <= 1'b0;
    repeat (12) @(posedge i_clk);
    chk(o_reset_pin_req, 1'b1);
    i_reset_pin_n <= 1'b1;
    repeat (12) @(posedge i_clk);
    chk(o_reset_pin_req, 1'b0);
  endtask
  task automatic t_unmapped;
    rdx(12'h200, rd, rs);
    chk({rd[29:0], rs}, {30'h0, `RESP_SLVERR});
    wr(12'h204, 32'h5A5A5A5A, rs);
    chk({30'h0, rs}, {30'h0, `RESP_SLVERR});
  endtask
  task automatic test_done;
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset;
    t_abort;
    t_por;
    t_relock;
    t_rerst;
    t_filter;
    t_unmapped;
    test_done;
  end
  initial begin
    repeat (4000) @(posedge i_clk);
    error_cnt++;
    test_done;
  end
endmodule
